// ==== common/flc_pkg.sv ====
/*
 * Shared constants and carrier types for the fault latch controller:
 * command codes, register widths, bit positions and reset values.
 * Assumes a host-side register port that presents one command per cycle.
 */
package flc_pkg;

    // ************************************************************
    // register command codes
    // ************************************************************
    localparam logic [7:0] CMD_FAULT_INST  = 8'h0E;
    localparam logic [7:0] CMD_ENABLE_MASK = 8'h0F;
    localparam logic [7:0] CMD_INDEX       = 8'h10;
    localparam logic [7:0] CMD_LATCHED     = 8'h11;

    // ************************************************************
    // widths, positions and reset values
    // ************************************************************
    localparam int          REG_W        = 16;
    localparam int          FLT_N        = 14;
    localparam int          RSV_N        = 2;
    localparam int          RSV_FIRST    = 14;
    localparam int          RSV_SECOND   = 15;
    localparam int          IDX_BIT      = 0;
    localparam int          B_CH0A_OV    = 0;
    localparam int          B_CH0A_UV    = 1;
    localparam int          B_CH0A_DAC   = 2;
    localparam int          B_CH1A_OV    = 5;
    localparam int          B_CH1A_UV    = 6;
    localparam int          B_CH1A_DAC   = 7;
    localparam logic [15:0] EN_RESET     = 16'h0000;
    localparam logic [15:0] DATA_RESET   = 16'h0000;
    localparam logic [13:0] LAT_RESET    = 14'h0000;
    localparam logic [1:0]  RSV_RESET    = 2'h0;

    // ************************************************************
    // carrier types
    // ************************************************************
    // live over/under-voltage comparator outputs
    typedef struct packed {
        logic ch0a_ov;
        logic ch0a_uv;
        logic ch0b_ov;
        logic ch0b_uv;
        logic ch1a_ov;
        logic ch1a_uv;
        logic ch1b_ov;
        logic ch1b_uv;
        logic core_ov;
        logic core_uv;
        logic v12_ov;
        logic v12_uv;
    } flc_mon_s;

    // one register request per cycle
    typedef struct packed {
        logic [7:0]  cmd;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } flc_req_s;

    // registered read answer
    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } flc_rsp_s;

endpackage

// ==== core/flc_fault_latch.sv ====
/*
 * Fault latch controller top: instantaneous fault assembly, enable mask,
 * sticky latched status with clear on read, summary index, alert drive
 * and fault-triggered re-servo pulses.
 * Assumes the host port carries one synchronous request per cycle and
 * that the servo engine acts on the one-cycle start pulses.
 */
// Functional notes
// - enable low forces latched bit zero; reset zero
// - enabled live fault sets its latched bit
// - re-servo disabled means no servo action
// - first channel re-servo pulses on fault
// - second channel re-servo pulses on fault
// - index bit zero shows any latched fault
// - index read keeps latches; upper bits zero
// - fixed fourteen-bit fault ordering
// - latched bit holds after fault goes away
// - writing enable zero clears latch immediately
// - reading latched status clears all bits without a live enabled fault
// - persisting enabled fault sets again after read
// - live fault register, same bit order
// - dac fault at code minimum or maximum
// - alert driven low while latched and enabled
`timescale 1ns/1ps

module flc_fault_latch #(
    parameter int DAC_W = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire flc_pkg::flc_req_s    req,
    output flc_pkg::flc_rsp_s         rsp,
    input  wire flc_pkg::flc_mon_s    mon,
    input  wire logic [DAC_W-1:0]     dac_code_first,
    input  wire logic [DAC_W-1:0]     dac_code_second,
    input  wire logic                 alert_disable,
    output logic                      alert_drive_n,
    output logic [flc_pkg::FLT_N-1:0] latched_fault_status,
    output logic                      reservo_start_first,
    output logic                      reservo_start_second
);

    // ************************************************************
    // helpers
    // ************************************************************
    // code rail-stuck at either end of its range
    function automatic logic dac_at_rail(input logic [DAC_W-1:0] code);
        dac_at_rail = (code == '0) || (code == '1);
    endfunction

    // a one-bit code cannot tell its two rails apart
    if (DAC_W < 2) begin
        $error("flc_fault_latch needs a dac code of two bits or more");
    end

    // ************************************************************
    // live fault vector
    // ************************************************************
    logic [flc_pkg::FLT_N-1:0] inst;

    // fixed ordering shared by live and latched views
    always_comb begin
        inst = {mon.v12_uv, mon.v12_ov, mon.core_uv, mon.core_ov,
                mon.ch1b_uv, mon.ch1b_ov,
                dac_at_rail(dac_code_second), mon.ch1a_uv, mon.ch1a_ov,
                mon.ch0b_uv, mon.ch0b_ov,
                dac_at_rail(dac_code_first), mon.ch0a_uv,
                mon.ch0a_ov};
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic [flc_pkg::REG_W-1:0] fault_enable_mask;
    logic [flc_pkg::REG_W-1:0] next_fault_enable_mask;
    logic [flc_pkg::FLT_N-1:0] next_latched;
    flc_pkg::flc_rsp_s         next_rsp;
    logic                      next_alert_drive_n;
    logic                      en_write;
    logic                      clr_read;
    logic                      any_latched_flag;

    // next values of enables, latches, answer and alert
    always_comb begin
        en_write = req.wr && (req.cmd == flc_pkg::CMD_ENABLE_MASK);
        clr_read = req.rd && (req.cmd == flc_pkg::CMD_LATCHED);
        any_latched_flag = |latched_fault_status;
        next_fault_enable_mask = fault_enable_mask;
        if (en_write) begin
            next_fault_enable_mask = req.wdata; // other writes dropped
        end
        // masking with the new enable clears in the same edge
        // live fault ored after the clear so set beats clear
        next_latched = ((clr_read ? flc_pkg::LAT_RESET
                                  : latched_fault_status) | inst)
                       & next_fault_enable_mask[flc_pkg::FLT_N-1:0];
        next_rsp.rvalid = req.rd;
        next_rsp.rdata  = flc_pkg::DATA_RESET;
        unique case (req.cmd)
            flc_pkg::CMD_FAULT_INST: begin
                next_rsp.rdata[flc_pkg::FLT_N-1:0] = inst;
            end
            flc_pkg::CMD_ENABLE_MASK: begin
                next_rsp.rdata = fault_enable_mask;
            end
            flc_pkg::CMD_INDEX: begin
                next_rsp.rdata[flc_pkg::IDX_BIT] = any_latched_flag;
            end
            flc_pkg::CMD_LATCHED: begin
                next_rsp.rdata[flc_pkg::FLT_N-1:0] =
                    latched_fault_status;
            end
            default: begin
                next_rsp.rdata = flc_pkg::DATA_RESET; // unmapped reads zero
            end
        endcase
        // open drain: only ever pulls low
        next_alert_drive_n = !(!alert_disable && any_latched_flag);
    end

    // registers only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fault_enable_mask    <= flc_pkg::EN_RESET;
            latched_fault_status <= flc_pkg::LAT_RESET;
            rsp                  <= '0;
            alert_drive_n        <= 1'b1;
        end else begin
            fault_enable_mask    <= next_fault_enable_mask;
            latched_fault_status <= next_latched;
            rsp                  <= next_rsp;
            alert_drive_n        <= next_alert_drive_n;
        end
    end

    // ************************************************************
    // re-servo triggers
    // ************************************************************
    // host must also set servo on, no repeat, monitor select
    flc_reservo_trig #(
        .NCH (flc_pkg::RSV_N)
    ) u_trig (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .enable      ({fault_enable_mask[flc_pkg::RSV_SECOND],
                       fault_enable_mask[flc_pkg::RSV_FIRST]}),
        .fault_level ({inst[flc_pkg::B_CH1A_OV] | inst[flc_pkg::B_CH1A_UV],
                       inst[flc_pkg::B_CH0A_OV] | inst[flc_pkg::B_CH0A_UV]}),
        .start       ({reservo_start_second, reservo_start_first})
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic [flc_pkg::FLT_N-1:0] en_low;
    assign en_low = fault_enable_mask[flc_pkg::FLT_N-1:0];

    sequence latched_read_s;
        req.rd && (req.cmd == flc_pkg::CMD_LATCHED) && !en_write;
    endsequence

    sequence quiet_s;
        !req.rd && !en_write;
    endsequence

    mask_forces_zero_a: assert property (
        (latched_fault_status & ~en_low) == '0)
        else $error("latched bit set while its enable is low");

    fault_sets_a: assert property (
        !en_write |=> ((latched_fault_status & $past(inst & en_low))
                       == $past(inst & en_low)))
        else $error("enabled live fault failed to latch");

    latch_holds_a: assert property (quiet_s |=>
        ((latched_fault_status & $past(latched_fault_status))
         == $past(latched_fault_status)))
        else $error("latched bit dropped without a clear");

    read_clears_a: assert property (
        latched_read_s ##0 (inst == '0) |=> latched_fault_status == '0)
        else $error("clearing read left bits set");

    set_keeps_a: assert property (
        latched_read_s |=> ((latched_fault_status & $past(inst & en_low))
                            == $past(inst & en_low)))
        else $error("fault lost in a clearing read");

    read_answer_a: assert property (
        latched_read_s |=> rsp.rvalid && (rsp.rdata ==
            {2'b00, $past(latched_fault_status)}))
        else $error("latched read answer wrong");

    index_answer_a: assert property (
        (req.rd && req.cmd == flc_pkg::CMD_INDEX && !en_write) |=>
        (rsp.rdata == {15'h0000, $past(any_latched_flag)}) &&
        ((latched_fault_status & $past(latched_fault_status))
         == $past(latched_fault_status)))
        else $error("index read wrong or disturbed latches");

    enable_clear_a: assert property (
        en_write |=> ((latched_fault_status & ~$past(req.wdata[13:0]))
                      == '0))
        else $error("writing enable low did not clear latch");

    dac_rail_a: assert property (
        inst[flc_pkg::B_CH0A_DAC] == dac_at_rail(dac_code_first) &&
        inst[flc_pkg::B_CH1A_DAC] == dac_at_rail(dac_code_second))
        else $error("dac fault bit does not follow rail code");

    alert_drive_a: assert property (
        (!alert_disable && any_latched_flag) |=> !alert_drive_n)
        else $error("alert not driven with latched fault");

    alert_off_a: assert property (
        alert_disable |=> alert_drive_n)
        else $error("alert driven while disabled");

endmodule

// ==== core/flc_reservo_trig.sv ====
/*
 * Single-shot re-servo trigger: one start pulse per rising fault edge
 * on each enabled channel. Assumes the fault levels are synchronous.
 */
`timescale 1ns/1ps

module flc_reservo_trig #(
    parameter int NCH = 2
) (
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic [NCH-1:0] enable,
    input  wire logic [NCH-1:0] fault_level,
    output logic      [NCH-1:0] start
);

    // ************************************************************
    // edge detect
    // ************************************************************
    logic [NCH-1:0] prev;
    logic [NCH-1:0] next_prev;
    logic [NCH-1:0] next_start;

    // refuse a channel count the trigger cannot serve
    if (NCH < 1) begin
        $error("flc_reservo_trig needs at least one channel");
    end

    // a held fault gives one servo only, never a retrigger loop
    always_comb begin
        next_prev  = fault_level;
        next_start = enable & fault_level & ~prev;
    end

    // registers only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev  <= '0;
            start <= '0;
        end else begin
            prev  <= next_prev;
            start <= next_start;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // disabled channel never servos
    no_servo_off_a: assert property (!enable[0] |=> !start[0])
        else $error("servo pulse on a disabled channel");

    // enabled channel fires on a new fault
    servo_fire_a: assert property (
        (enable[0] && fault_level[0] && !prev[0]) |=> start[0])
        else $error("missing servo pulse after fault edge");

    // second channel fires on a new fault
    servo_fire_second_a: assert property (
        (enable[NCH-1] && fault_level[NCH-1] && !prev[NCH-1]) |=>
        start[NCH-1])
        else $error("missing second channel servo pulse");

    // second channel pulse is one cycle only
    servo_single_a: assert property (
        start[NCH-1] |=> !start[NCH-1])
        else $error("servo pulse longer than one cycle");

endmodule

// ==== tb/fault_latch_controller_test.sv ====
/*
 * Self-checking bench for the fault latch controller top.
 * Assumes flc_pkg and the host model; inputs change at falling edges.
 */
`timescale 1ns/1ps

module fault_latch_controller_test;
    logic              ref_clk;
    logic              nrst;
    logic              alert_disable;
    logic              alert_drive_n;
    logic              reservo_start_first;
    logic              reservo_start_second;
    flc_pkg::flc_req_s req;
    flc_pkg::flc_rsp_s rsp;
    flc_pkg::flc_mon_s mon;
    logic [7:0]        dac0;
    logic [7:0]        dac1;
    logic [13:0]       lat;
    logic [13:0]       exp;
    logic [15:0]       q;
    logic [15:0]       m;
    int                err_total;
    int                checks;
    int                cyc;
    int                np0;
    int                np1;
    int                a0;
    int                a1;

    flc_fault_latch i_flc_fault_latch (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .req                  (req),
        .rsp                  (rsp),
        .mon                  (mon),
        .dac_code_first       (dac0),
        .dac_code_second      (dac1),
        .alert_disable        (alert_disable),
        .alert_drive_n        (alert_drive_n),
        .latched_fault_status (lat),
        .reservo_start_first  (reservo_start_first),
        .reservo_start_second (reservo_start_second)
    );

    flc_host_model i_flc_host_model (
        .ref_clk (ref_clk),
        .rsp     (rsp),
        .req     (req)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // live fault word in latch bit order
    function automatic logic [13:0] inst_of(flc_pkg::flc_mon_s v,
                                            logic [7:0] a, logic [7:0] b);
        return {v.v12_uv, v.v12_ov, v.core_uv, v.core_ov, v.ch1b_uv,
                v.ch1b_ov, (b == 8'h00 || b == 8'hFF), v.ch1a_uv,
                v.ch1a_ov, v.ch0b_uv, v.ch0b_ov,
                (a == 8'h00 || a == 8'hFF), v.ch0a_uv, v.ch0a_ov};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        checks++;
        if (got !== want) begin
            err_total++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic rd(input logic [7:0] c);
        i_flc_host_model.acc(c, 1'b0, 16'h0000, q);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] unused;
        i_flc_host_model.acc(c, 1'b1, d, unused);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // clock, pulse counting and hang guard
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // pulses counted at the falling edge, where they are settled;
    // limit far above run
    always @(negedge ref_clk) begin
        cyc++;
        np0 += int'(reservo_start_first);
        np1 += int'(reservo_start_second);
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        nrst = 1'b0;
        alert_disable = 1'b0;
        mon = '0;
        dac0 = 8'h80;
        dac1 = 8'h80;
        {cyc, err_total, checks, np0, np1} = '0;
        void'($urandom(32'hB21D));
        settle(4);
        nrst = 1'b1;
        chk(16'(lat), 16'h0000);
        rd(flc_pkg::CMD_ENABLE_MASK);
        chk(q, 16'h0000);
        // every condition live, none enabled: nothing latches
        mon = '1;
        dac0 = 8'h00;
        dac1 = 8'hFF;
        settle(3);
        chk(16'(lat), 16'h0000);
        rd(flc_pkg::CMD_FAULT_INST);
        chk(q, {2'b00, inst_of(mon, dac0, dac1)});
        $display("test disabled done");
        // quiet inputs so the first enable write latches nothing stale
        mon = '0;
        dac0 = 8'h80;
        dac1 = 8'h80;
        for (int i = 0; i < 12; i++) begin
            m = {2'b00, 14'($urandom)};
            wr(flc_pkg::CMD_ENABLE_MASK, m);
            mon = flc_pkg::flc_mon_s'(12'($urandom));
            dac0 = (i % 3 == 0) ? 8'h00 : 8'($urandom);
            dac1 = (i % 3 == 1) ? 8'hFF : 8'($urandom);
            exp = inst_of(mon, dac0, dac1) & m[13:0];
            settle(2);
            chk(16'(lat), 16'(exp));
            mon = '0;
            dac0 = 8'h80;
            dac1 = 8'h80;
            settle(2);
            chk(16'(lat), 16'(exp));
            chk(16'(alert_drive_n), 16'(!(|exp)));
            rd(flc_pkg::CMD_INDEX);
            chk(q, {15'h0000, |exp});
            chk(16'(lat), 16'(exp));
            rd(flc_pkg::CMD_LATCHED);
            chk(q, {2'b00, exp});
            chk(16'(lat), 16'h0000);
            $display("test random %0d done", i);
        end
        // fault held across a clearing read sets again at once
        wr(flc_pkg::CMD_ENABLE_MASK, 16'h3FFF);
        mon.ch0a_ov = 1'b1;
        settle(2);
        rd(flc_pkg::CMD_LATCHED);
        chk(q, 16'h0001);
        chk(16'(lat), 16'h0001);
        wr(flc_pkg::CMD_ENABLE_MASK, 16'h3FFE);
        chk(16'(lat), 16'h0000);
        wr(flc_pkg::CMD_ENABLE_MASK, 16'h3FFF);
        settle(1);
        wr(flc_pkg::CMD_LATCHED, 16'h0000);
        wr(flc_pkg::CMD_INDEX, 16'h0000);
        chk(16'(lat), 16'h0001);
        rd(flc_pkg::CMD_ENABLE_MASK);
        chk(q, 16'h3FFF);
        alert_disable = 1'b1;
        settle(2);
        chk(16'(alert_drive_n), 16'h0001);
        alert_disable = 1'b0;
        mon = '0;
        $display("test clear paths done");
        // re-servo off, then on for both channels with held faults
        for (int k = 0; k < 2; k++) begin
            wr(flc_pkg::CMD_ENABLE_MASK, k ? 16'hC000 : 16'h0000);
            a0 = np0;
            a1 = np1;
            mon.ch0a_ov = 1'b1;
            mon.ch1a_uv = 1'b1;
            settle(6);
            mon = '0;
            settle(3);
            chk(16'(np0 - a0), 16'(k));
            chk(16'(np1 - a1), 16'(k));
        end
        $display("test reservo done");
        report_and_stop();
    end
endmodule

// ==== tb/flc_host_model.sv ====
/*
 * Host model for the fault latch: issues one register request at a time.
 * Assumes a free running ref_clk; requests change at the falling edge.
 */
`timescale 1ns/1ps

module flc_host_model (
    input  wire logic              ref_clk,
    input  wire flc_pkg::flc_rsp_s rsp,
    output flc_pkg::flc_req_s      req
);
    // ************************************************************
    // request driver
    // ************************************************************
    // idle bus starts quiet
    initial req = '0;

    // servo setup (no repeat, monitor select high) is assumed done
    // before any re-servo enable is written; held over one rising edge
    task automatic acc(input logic [7:0] c, input logic w,
                       input logic [15:0] d, output logic [15:0] q);
        @(negedge ref_clk);
        req = '{cmd: c, wr: w, rd: !w, wdata: d};
        @(negedge ref_clk);
        // idle shows the inverse so stale values are never trusted
        req = '{cmd: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
        q = rsp.rvalid ? rsp.rdata : 16'hXXXX;
    endtask
endmodule
